// File: bench/test_spdif_autobuffer_status_regs.sv
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the autobuffer status register group
// Assumes: one-cycle read and write strobes, read data one cycle after the strobe
// Notes:   all inputs change on the rising edge by non-blocking assignment
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module test_spdif_autobuffer_status_regs;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [6:0] i_reg_addr = 7'h00;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [7:0] i_reg_wdata = 8'h00;
   logic [7:0] o_reg_rdata;
   logic [14:0] i_rate_ratio = 15'h0000;
   logic i_nonaudio = 1'b0;
   logic [15:0] i_preamble_c = 16'h0000;
   logic i_rx_user_valid = 1'b0;
   logic i_rx_user_bit = 1'b0;
   logic i_rx_chan_valid = 1'b0;
   logic i_rx_chan_bit = 1'b0;
   logic o_tx_user_valid, o_tx_user_bit, o_tx_chan_valid, o_tx_chan_bit;
   logic [15:0] o_message_gap;
   logic o_unit_gap_adjust_en;
   logic [3:0] o_unit_gap_max;
   logic o_unit_gap_max_bad;
   int n_mismatch = 0;
   int compares = 0;
   logic [3:0] f;

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

   spdif_autobuffer_status_regs uut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_rate_ratio(i_rate_ratio),
      .i_nonaudio(i_nonaudio), .i_preamble_c(i_preamble_c),
      .i_rx_user_valid(i_rx_user_valid), .i_rx_user_bit(i_rx_user_bit),
      .i_rx_chan_valid(i_rx_chan_valid), .i_rx_chan_bit(i_rx_chan_bit),
      .o_tx_user_valid(o_tx_user_valid), .o_tx_user_bit(o_tx_user_bit),
      .o_tx_chan_valid(o_tx_chan_valid), .o_tx_chan_bit(o_tx_chan_bit),
      .o_message_gap(o_message_gap), .o_unit_gap_adjust_en(o_unit_gap_adjust_en),
      .o_unit_gap_max(o_unit_gap_max), .o_unit_gap_max_bad(o_unit_gap_max_bad));

   // 250 MHz system clock
   always #2 i_sys_clk = ~i_sys_clk;

   //---------------------------------------------------------------------------
   // control port tasks
   //---------------------------------------------------------------------------
   // strobe lasts one cycle; the #1 lets the taking edge settle before checks
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_wr <= 1'b0;
      #1;
   endtask : reg_write

   // read data is registered on the edge that takes the strobe
   task automatic check_read(input logic [6:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1;
      `CHK(o_reg_rdata, e)
   endtask : check_read

   // one receiver bit on both streams, checked one cycle later
   task automatic pulse_bits(input logic ue, input logic ce, input logic b);
      @(posedge i_sys_clk);
      i_rx_user_valid <= 1'b1;
      i_rx_user_bit <= b;
      i_rx_chan_valid <= 1'b1;
      i_rx_chan_bit <= b;
      @(posedge i_sys_clk);
      i_rx_user_valid <= 1'b0;
      i_rx_chan_valid <= 1'b0;
      #1;
      `CHK({o_tx_user_valid, o_tx_user_bit}, {ue, ue & b})
      `CHK({o_tx_chan_valid, o_tx_chan_bit}, {ce, ce & b})
   endtask : pulse_bits

   // single place where the run ends
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // watchdog so a stuck sequence still reaches the verdict
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      n_mismatch++;
      $display("watchdog expired");
      stop_test();
   end

   //---------------------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      `CHK(o_message_gap, 16'h0009)
      check_read(7'h0F, 8'h00);
      check_read(7'h10, 8'h09);
      check_read(7'h11, 8'h00);
      $display("test reset values done");
      reg_write(7'h0F, 8'hA5);
      reg_write(7'h10, 8'h3C);
      `CHK(o_message_gap, 16'hA53C)
      check_read(7'h0F, 8'hA5);
      check_read(7'h10, 8'h3C);
      $display("test message gap done");
      // gap maximum range, reserved bit 7 dropped
      reg_write(7'h11, 8'hFF);
      check_read(7'h11, 8'h7F);
      for (int i = 0; i < 16; i++)
      begin
         f = i[3:0];
         reg_write(7'h11, {4'h4, f});
         `CHK(o_unit_gap_max, (f > 4'h8) ? 4'h8 : f)
         `CHK(o_unit_gap_max_bad, f > 4'h8)
      end
      // adjust off means no gap change
      reg_write(7'h11, 8'h05);
      `CHK({o_unit_gap_adjust_en, o_unit_gap_max}, 5'h00)
      $display("test unit gap done");
      for (int k = 0; k < 4; k++)
      begin
         reg_write(7'h11, {2'b00, k[1:0], 4'h0});
         pulse_bits(k[1], k[0], 1'b1);
         pulse_bits(k[1], k[0], 1'b0);
      end
      $display("test passthrough done");
      // coherent ratio across two byte reads
      @(posedge i_sys_clk);
      i_rate_ratio <= 15'h7A3C;
      repeat (2) @(posedge i_sys_clk);
      check_read(7'h12, 8'h7A);
      @(posedge i_sys_clk);
      i_rate_ratio <= 15'h0155;
      repeat (2) @(posedge i_sys_clk);
      check_read(7'h13, 8'h3C);
      reg_write(7'h12, 8'hFF);
      reg_write(7'h13, 8'hFF);
      check_read(7'h12, 8'h01);
      check_read(7'h13, 8'h55);
      // back-to-back pair stays coherent while the live ratio moves
      @(posedge i_sys_clk);
      i_reg_addr <= 7'h12;
      i_reg_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_reg_addr <= 7'h13;
      i_rate_ratio <= 15'h2B66;
      #1;
      `CHK(o_reg_rdata, 8'h01)
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      #1;
      `CHK(o_reg_rdata, 8'h55)
      check_read(7'h12, 8'h2B);
      $display("test rate ratio done");
      @(posedge i_sys_clk);
      i_nonaudio <= 1'b1;
      i_preamble_c <= 16'hBEEF;
      repeat (2) @(posedge i_sys_clk);
      check_read(7'h14, 8'hBE);
      check_read(7'h15, 8'hEF);
      reg_write(7'h14, 8'h00);
      check_read(7'h14, 8'hBE);
      @(posedge i_sys_clk);
      i_nonaudio <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      check_read(7'h14, 8'h00);
      check_read(7'h15, 8'h00);
      $display("test preamble done");
      // mid-run reset returns the gap bytes to their reset values 0x00 and 0x09
      @(posedge i_sys_clk);
      i_reset <= 1'b1;
      repeat (3) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      `CHK(o_message_gap, 16'h0009)
      check_read(7'h11, 8'h00);
      check_read(7'h10, 8'h09);
      // unmapped place ignores writes and reads zero
      reg_write(7'h30, 8'hFF);
      check_read(7'h30, 8'h00);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule : test_spdif_autobuffer_status_regs

// File: hdl/ratio_snapshot.sv
//------------------------------------------------------------------------------
// Purpose: keeps a multi-byte status word coherent across two byte reads
// Assumes: the high byte is read before the low byte
// Notes:   tracks the live word until the high byte is read
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module ratio_snapshot #(
   parameter int WIDTH = 15
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_live,
   input wire logic i_take_hi,
   input wire logic i_take_lo,
   output logic [WIDTH-1:0] o_word
);

   logic held;

   // a hold flag freezes the whole word so a slow reader sees one sample
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         held <= 1'b0;
      else if (i_take_hi)
         held <= 1'b1;
      else if (i_take_lo)
         held <= 1'b0;
   end

   // live tracking while not held
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         o_word <= '0;
      else if (!held || i_take_hi)
         o_word <= i_live;
   end

endmodule : ratio_snapshot

// File: hdl/spdif_autobuf_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and types for the autobuffer status register group
// Assumes: 7-bit register addresses and 8-bit register data on the control port
// Notes:   register offsets, reset values and field limits live here; the assertions repeat them as literals
//------------------------------------------------------------------------------
// Summary of operation
// RULE1 - message gap is a 16-bit zero count, high byte at 0x0F, low at 0x10
// RULE2 - gap bytes reset to 0x00 and 0x09, nine zeros between messages
// RULE3 - unit-gap adjust disabled means no zeros added or removed between units
// RULE4 - user bits and channel-status bits pass through only when each is enabled
// RULE5 - ratio bits 14..8 read at 0x12 bits 6..0, bit 7 reads zero
// RULE6 - ratio bits 7..0 read at 0x13
// RULE7 - 0x14 reads preamble-C high byte when nonaudio, else zero
// RULE8 - 0x15 reads preamble-C low byte when nonaudio, else zero
// RULE9 - unit-gap maximum is 0 to 8; larger codes are flagged unsupported
package spdif_autobuf_pkg;

   //---------------------------------------------------------------------------
   // register map
   //---------------------------------------------------------------------------
   localparam logic [6:0] MSG_GAP_HI_ADDR = 7'h0F;
   localparam logic [6:0] MSG_GAP_LO_ADDR = 7'h10;
   localparam logic [6:0] AUTOBUF_ADDR = 7'h11;
   localparam logic [6:0] RATIO_HI_ADDR = 7'h12;
   localparam logic [6:0] RATIO_LO_ADDR = 7'h13;
   localparam logic [6:0] PRE_C_HI_ADDR = 7'h14;
   localparam logic [6:0] PRE_C_LO_ADDR = 7'h15;

   //---------------------------------------------------------------------------
   // reset values and field limits
   //---------------------------------------------------------------------------
   localparam logic [7:0] MSG_GAP_HI_RESET = 8'h00;
   localparam logic [7:0] MSG_GAP_LO_RESET = 8'h09;
   localparam logic [7:0] AUTOBUF_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] UNIT_GAP_LIMIT = 4'h8;
   localparam int RATIO_WIDTH = 15;
   localparam int PREAMBLE_WIDTH = 16;

   // autobuffer register fields, bit 7 first
   typedef struct packed {
      logic reserved;
      logic unit_gap_adjust_en;
      logic user_bit_passthru_en;
      logic chan_stat_passthru_en;
      logic [3:0] unit_gap_max;
   } autobuf_ctrl_type;

   // one bit travelling from receiver to transmitter
   typedef struct packed {
      logic valid;
      logic data;
   } stream_bit_type;

endpackage : spdif_autobuf_pkg

// File: hdl/spdif_autobuffer_status_regs.sv
//------------------------------------------------------------------------------
// Purpose: message-gap, autobuffer, rate-ratio and preamble-C registers
// Assumes: control port strobes are one-cycle pulses synchronous to i_sys_clk
// Notes:   read data appears one cycle after the read strobe and holds
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module spdif_autobuffer_status_regs (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [6:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic [14:0] i_rate_ratio,
   input wire logic i_nonaudio,
   input wire logic [15:0] i_preamble_c,
   input wire logic i_rx_user_valid,
   input wire logic i_rx_user_bit,
   input wire logic i_rx_chan_valid,
   input wire logic i_rx_chan_bit,
   output logic o_tx_user_valid,
   output logic o_tx_user_bit,
   output logic o_tx_chan_valid,
   output logic o_tx_chan_bit,
   output logic [15:0] o_message_gap,
   output logic o_unit_gap_adjust_en,
   output logic [3:0] o_unit_gap_max,
   output logic o_unit_gap_max_bad
);

   //---------------------------------------------------------------------------
   // writable registers
   //---------------------------------------------------------------------------
   logic [7:0] message_gap_hi;
   logic [7:0] message_gap_lo;
   spdif_autobuf_pkg::autobuf_ctrl_type autobuf;
   spdif_autobuf_pkg::stream_bit_type user_out;
   spdif_autobuf_pkg::stream_bit_type chan_out;
   logic [14:0] ratio_word;
   logic [15:0] preamble_c;
   logic [7:0] next_rdata;
   logic autobuf_we;
   spdif_autobuf_pkg::autobuf_ctrl_type next_autobuf;

   // RULE1 gap byte writes
   // RULE2 gap reset values
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         message_gap_hi <= spdif_autobuf_pkg::MSG_GAP_HI_RESET;
         message_gap_lo <= spdif_autobuf_pkg::MSG_GAP_LO_RESET;
      end
      else if (i_reg_wr)
      begin
         if (i_reg_addr == spdif_autobuf_pkg::MSG_GAP_HI_ADDR)
            message_gap_hi <= i_reg_wdata;
         if (i_reg_addr == spdif_autobuf_pkg::MSG_GAP_LO_ADDR)
            message_gap_lo <= i_reg_wdata;
      end
   end

   // autobuffer control write; the reserved bit is never stored
   assign autobuf_we = i_reg_wr && i_reg_addr == spdif_autobuf_pkg::AUTOBUF_ADDR;
   assign next_autobuf = {1'b0, i_reg_wdata[6:0]};

   // stored control byte
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         autobuf <= spdif_autobuf_pkg::AUTOBUF_RESET;
      else if (autobuf_we)
         autobuf <= next_autobuf;
   end

   // RULE1 joined gap count
   assign o_message_gap = {message_gap_hi, message_gap_lo};

   //---------------------------------------------------------------------------
   // unit-gap limit seen by the stuffing logic
   //---------------------------------------------------------------------------
   assign o_unit_gap_adjust_en = autobuf.unit_gap_adjust_en;

   // RULE3 zero limit when off
   // RULE9 clamp to eight; an unsupported code must not overrun the stuffer
   // registered from the written byte, so the limit lands with the register itself
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_unit_gap_max <= 4'h0;
         o_unit_gap_max_bad <= 1'b0;
      end
      else if (autobuf_we)
      begin
         o_unit_gap_max_bad <= next_autobuf.unit_gap_max > spdif_autobuf_pkg::UNIT_GAP_LIMIT;
         if (!next_autobuf.unit_gap_adjust_en)
            o_unit_gap_max <= 4'h0;
         else if (next_autobuf.unit_gap_max > spdif_autobuf_pkg::UNIT_GAP_LIMIT)
            o_unit_gap_max <= spdif_autobuf_pkg::UNIT_GAP_LIMIT;
         else
            o_unit_gap_max <= next_autobuf.unit_gap_max;
      end
   end

   //---------------------------------------------------------------------------
   // receiver to transmitter passthrough
   //---------------------------------------------------------------------------
   // RULE4 user bit gating
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         user_out <= '0;
      else
      begin
         user_out.valid <= i_rx_user_valid && autobuf.user_bit_passthru_en;
         user_out.data <= i_rx_user_bit && autobuf.user_bit_passthru_en;
      end
   end

   // RULE4 channel status gating
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         chan_out <= '0;
      else
      begin
         chan_out.valid <= i_rx_chan_valid && autobuf.chan_stat_passthru_en;
         chan_out.data <= i_rx_chan_bit && autobuf.chan_stat_passthru_en;
      end
   end

   assign o_tx_user_valid = user_out.valid;
   assign o_tx_user_bit = user_out.data;
   assign o_tx_chan_valid = chan_out.valid;
   assign o_tx_chan_bit = chan_out.data;

   //---------------------------------------------------------------------------
   // status capture
   //---------------------------------------------------------------------------
   // a read of the high byte freezes the low byte so both halves match
   ratio_snapshot #(
      .WIDTH(spdif_autobuf_pkg::RATIO_WIDTH)
   ) u_ratio (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_live(i_rate_ratio),
      .i_take_hi(i_reg_rd && i_reg_addr == spdif_autobuf_pkg::RATIO_HI_ADDR),
      .i_take_lo(i_reg_rd && i_reg_addr == spdif_autobuf_pkg::RATIO_LO_ADDR),
      .o_word(ratio_word)
   );

   // RULE7 preamble zeroed when audio
   // RULE8 same gate for low byte
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         preamble_c <= '0;
      else
         preamble_c <= i_nonaudio ? i_preamble_c : 16'h0000;
   end

   //---------------------------------------------------------------------------
   // read mux
   //---------------------------------------------------------------------------
   // RULE5 high ratio byte, bit 7 zero
   // RULE6 low ratio byte from snapshot
   always_comb
   begin
      unique case (i_reg_addr)
         spdif_autobuf_pkg::MSG_GAP_HI_ADDR: next_rdata = message_gap_hi;
         spdif_autobuf_pkg::MSG_GAP_LO_ADDR: next_rdata = message_gap_lo;
         spdif_autobuf_pkg::AUTOBUF_ADDR: next_rdata = autobuf;
         spdif_autobuf_pkg::RATIO_HI_ADDR: next_rdata = {1'b0, i_rate_ratio[14:8]};
         spdif_autobuf_pkg::RATIO_LO_ADDR: next_rdata = ratio_word[7:0];
         spdif_autobuf_pkg::PRE_C_HI_ADDR: next_rdata = preamble_c[15:8];
         spdif_autobuf_pkg::PRE_C_LO_ADDR: next_rdata = preamble_c[7:0];
         default: next_rdata = spdif_autobuf_pkg::UNMAPPED_READ;
      endcase
   end

   // read data holds until the next read strobe
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
         o_reg_rdata <= next_rdata;
   end

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   a_gap_hi_write: assert property ( // RULE1
      (i_reg_wr && i_reg_addr == 7'h0F) |=> o_message_gap[15:8] == $past(i_reg_wdata))
      else $error("gap high byte not written");

   a_gap_lo_write: assert property ( // RULE1
      (i_reg_wr && i_reg_addr == 7'h10) |=> o_message_gap[7:0] == $past(i_reg_wdata))
      else $error("gap low byte not written");

   a_gap_reset_value: assert property (disable iff (1'b0) // RULE2
      $past(i_reset) |-> o_message_gap == 16'h0009)
      else $error("gap count wrong after reset");

   a_adjust_off_zero: assert property ( // RULE3
      !o_unit_gap_adjust_en |-> o_unit_gap_max == 4'h0)
      else $error("gap limit nonzero while adjust off");

   a_user_pass_gate: assert property ( // RULE4
      o_tx_user_valid |-> $past(i_rx_user_valid && autobuf.user_bit_passthru_en)
         && o_tx_user_bit == $past(i_rx_user_bit))
      else $error("user bit passed while disabled");

   a_chan_pass_gate: assert property ( // RULE4
      o_tx_chan_valid |-> $past(i_rx_chan_valid && autobuf.chan_stat_passthru_en)
         && o_tx_chan_bit == $past(i_rx_chan_bit))
      else $error("channel status bit passed while disabled");

   a_ratio_hi_read: assert property ( // RULE5
      (i_reg_rd && i_reg_addr == 7'h12) |=>
         o_reg_rdata == {1'b0, $past(i_rate_ratio[14:8])})
      else $error("ratio high byte read wrong");

   a_ratio_pair_read: assert property ( // RULE6
      (i_reg_rd && i_reg_addr == 7'h12) ##1 (i_reg_rd && i_reg_addr == 7'h13) |=>
         o_reg_rdata == $past(i_rate_ratio[7:0], 2))
      else $error("ratio low byte not coherent");

   a_pre_hi_audio: assert property ( // RULE7
      (i_reg_rd && i_reg_addr == 7'h14 && !$past(i_nonaudio)) |=> o_reg_rdata == 8'h00)
      else $error("preamble high byte not zero for audio");

   a_pre_lo_nonaudio: assert property ( // RULE8
      (i_reg_rd && i_reg_addr == 7'h15 && $past(i_nonaudio)) |=>
         o_reg_rdata == $past(i_preamble_c[7:0], 2))
      else $error("preamble low byte wrong for nonaudio");

   a_gap_max_bound: assert property ( // RULE9
      o_unit_gap_max <= 4'h8 && (o_unit_gap_max_bad == (autobuf.unit_gap_max > 4'h8)))
      else $error("unit gap limit out of range");

   c_user_passing: cover property (o_tx_user_valid ##1 o_tx_user_valid);
   c_ratio_pair: cover property (
      (i_reg_rd && i_reg_addr == 7'h12) ##1 (i_reg_rd && i_reg_addr == 7'h13));
   c_gap_clamped: cover property (o_unit_gap_adjust_en && o_unit_gap_max_bad);
   c_nonaudio_read: cover property (i_nonaudio ##1 (i_reg_rd && i_reg_addr == 7'h14));

endmodule : spdif_autobuffer_status_regs
